// ---- rtl/sdc_device.sv ----
// device end: command and control input stage of the memory
`timescale 1ns/10ps
module sdc_device #(
   parameter int ADDR_W = sdc_pkg::ADDR_W,
   parameter int BA_W   = sdc_pkg::BA_W,
   parameter int RANKS  = 1,
   parameter int RANK   = 0,
   parameter int NBANK  = 1 << BA_W
) (
   input  wire logic              mclk,         // system clock
   input  wire logic              rst_n,        // synchronous reset, active low
   sdc_link_if.dev                link,         // pins from the controller
   output logic                   cmd_valid,    // one-cycle pulse per decoded command
   output sdc_pkg::sdc_cmd_t      cmd_code,     // last decoded command
   output logic [BA_W-1:0]        cmd_bank,     // bank of last command that uses one
   output logic [ADDR_W-1:0]      cmd_addr,     // row, column or op code of last command that uses the address
   output logic                   cmd_ap,       // auto precharge or close-all flag
   output logic                   mode_wr,      // one-cycle pulse on mode load
   output logic [ADDR_W-1:0]      mode_reg [sdc_pkg::NUM_MODE_REGS], // mode registers
   output logic [NBANK-1:0]       bank_open,    // banks holding an open row
   output sdc_pkg::sdc_pwr_t      pwr_state,    // power state
   output logic                   clk_active,   // internal clocking running
   output logic                   cmd_buf_en,   // address and command buffers on
   output logic                   ck_buf_en,    // clock and termination buffers on
   output logic                   term_on       // termination applied
);
   localparam int SW = 8 + BA_W + ADDR_W;

   logic [SW-1:0]     pins;
   logic [SW-1:0]     pins_s;
   logic              ck_s;
   logic              ck_n_s;
   logic              cke_s;
   logic              odt_s;
   logic              cs_n_s;
   logic [2:0]        strobe_s;
   logic [BA_W-1:0]   ba_s;
   logic [ADDR_W-1:0] addr_s;
   logic              ck_hi_r;
   logic              cke_prev_r;
   logic              xing;
   logic              term_en;
   sdc_pkg::sdc_cmd_t cmd_w;

   // ==========================================================
   // pin capture: every pin passes the same three stages so the
   // bundle keeps its relative timing
   assign pins = {link.true_clock_input, link.complement_clock_input, link.cke,
                  link.termination_control_input, link.cs_n[RANK], link.ras_n,
                  link.cas_n, link.we_n, link.ba, link.addr};

   sdc_sync3 #(
      .W (SW)
   ) u_sync (
      .mclk  (mclk),
      .rst_n (rst_n),
      .d     (pins),
      .q     (pins_s)
   );

   assign {ck_s, ck_n_s, cke_s, odt_s, cs_n_s, strobe_s, ba_s, addr_s} = pins_s;

   // ==========================================================
   // rising crossing detector; clock buffer off in self refresh
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ck_hi_r <= 1'b0;
      end else begin
         ck_hi_r <= ck_s & ~ck_n_s;
      end
   end

   assign xing = ck_s & ~ck_n_s & ~ck_hi_r & ck_buf_en;

   // ==========================================================
   // command decode
   always_comb begin
      // command buffers off when powered down
      if (cs_n_s || !cmd_buf_en) begin
         cmd_w = sdc_pkg::CMD_DES;
      end else begin
         cmd_w = sdc_pkg::sdc_cmd_t'({1'b0, strobe_s});
      end
   end

   // ==========================================================
   // power state, entry at a crossing; power-down exit at a crossing, self refresh exit by gate level
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         pwr_state <= sdc_pkg::PWR_ON;
      end else begin
         case (pwr_state)
            sdc_pkg::PWR_ON: begin
               if (xing && !cke_s) begin
                  if (cmd_w == sdc_pkg::CMD_REF) begin
                     pwr_state <= sdc_pkg::PWR_SR;
                  end else if (|bank_open) begin
                     pwr_state <= sdc_pkg::PWR_APD;
                  end else begin
                     pwr_state <= sdc_pkg::PWR_PPD;
                  end
               end
            end
            sdc_pkg::PWR_PPD, sdc_pkg::PWR_APD: begin
               if (xing && cke_s) begin
                  pwr_state <= sdc_pkg::PWR_ON;
               end
            end
            sdc_pkg::PWR_SR: begin
               if (cke_s) begin
                  pwr_state <= sdc_pkg::PWR_ON;
               end
            end
            default: begin
               pwr_state <= sdc_pkg::PWR_ON;
            end
         endcase
      end
   end

   // ==========================================================
   // internal clocking follows the gate; self refresh exit on the gate's rising edge, no crossing needed
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         clk_active <= 1'b1;
         cke_prev_r <= 1'b0;
      end else begin
         cke_prev_r <= cke_s;
         if (xing) begin
            clk_active <= cke_s;
         end else if (pwr_state == sdc_pkg::PWR_SR && cke_s && !cke_prev_r) begin
            clk_active <= 1'b1;
         end
      end
   end

   assign cmd_buf_en = (pwr_state == sdc_pkg::PWR_ON);
   assign ck_buf_en  = (pwr_state != sdc_pkg::PWR_SR);

   // ==========================================================
   // command capture; address held for commands that do not use it
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cmd_valid <= 1'b0;
         cmd_code  <= sdc_pkg::CMD_DES;
         cmd_bank  <= '0;
         cmd_addr  <= '0;
         cmd_ap    <= 1'b0;
      end else begin
         cmd_valid <= 1'b0;
         if (xing && cke_s && cmd_w != sdc_pkg::CMD_DES) begin
            cmd_valid <= 1'b1;
            cmd_code  <= cmd_w;
            case (cmd_w)
               sdc_pkg::CMD_ACT, sdc_pkg::CMD_RD, sdc_pkg::CMD_WR,
               sdc_pkg::CMD_PRE, sdc_pkg::CMD_LMR: begin
                  cmd_bank <= ba_s;
                  cmd_addr <= addr_s;
                  cmd_ap   <= addr_s[sdc_pkg::AP_BIT];
               end
               default: begin
                  cmd_ap <= 1'b0;
               end
            endcase
         end
      end
   end

   // ==========================================================
   // open row tracking; auto precharge closes the bank at once,
   // a simplification since burst timing is outside this stage
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         bank_open <= '0;
      end else if (xing && cke_s) begin
         case (cmd_w)
            sdc_pkg::CMD_ACT: begin
               bank_open[ba_s] <= 1'b1;
            end
            sdc_pkg::CMD_PRE: begin
               if (addr_s[sdc_pkg::AP_BIT]) begin
                  bank_open <= '0;
               end else begin
                  bank_open[ba_s] <= 1'b0;
               end
            end
            sdc_pkg::CMD_RD, sdc_pkg::CMD_WR: begin
               if (addr_s[sdc_pkg::AP_BIT]) begin
                  bank_open[ba_s] <= 1'b0;
               end
            end
            default: begin
               bank_open <= bank_open;
            end
         endcase
      end
   end

   // ==========================================================
   // mode registers
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         mode_wr <= 1'b0;
         for (int i = 0; i < sdc_pkg::NUM_MODE_REGS; i++) begin
            mode_reg[i] <= sdc_pkg::MODE_RST;
         end
      end else begin
         mode_wr <= 1'b0;
         if (xing && cke_s && cmd_w == sdc_pkg::CMD_LMR) begin
            mode_wr <= 1'b1;
            mode_reg[ba_s[sdc_pkg::MSEL_W-1:0]] <= addr_s;
         end
      end
   end

   // ==========================================================
   // termination control, sampled at crossings while its buffer is on
   assign term_en = mode_reg[sdc_pkg::MSEL_EXT][sdc_pkg::TERM_HI_BIT]
                  | mode_reg[sdc_pkg::MSEL_EXT][sdc_pkg::TERM_LO_BIT];

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         term_on <= 1'b0;
      end else if (!ck_buf_en) begin
         term_on <= 1'b0;
      end else if (xing) begin
         term_on <= odt_s & term_en;
      end
   end
endmodule

// ---- rtl/sdc_host.sv ----
// controller end: drives link clock and paces commands onto the pins
`timescale 1ns/10ps
module sdc_host #(
   parameter int ADDR_W = sdc_pkg::ADDR_W,
   parameter int BA_W   = sdc_pkg::BA_W,
   parameter int RANKS  = 1,
   parameter int RANK_W = (RANKS > 1) ? $clog2(RANKS) : 1
) (
   input  wire logic              mclk,       // system clock
   input  wire logic              rst_n,      // synchronous reset, active low
   input  wire logic              req_valid,  // a command is offered
   output logic                   req_ready,  // command taken this cycle
   input  wire sdc_pkg::sdc_cmd_t req_cmd,    // command to send
   input  wire logic [RANK_W-1:0] req_rank,   // target rank
   input  wire logic [BA_W-1:0]   req_bank,   // bank select
   input  wire logic [ADDR_W-1:0] req_addr,   // address or op code
   input  wire logic              req_cke,    // clock-gate level to present
   input  wire logic              req_odt,    // termination request
   sdc_link_if.host               link        // pins toward the device
);
   localparam int HALF = sdc_pkg::CK_HALF_CYC;
   localparam int CW   = $clog2(HALF) + 1;

   logic              ck_r;
   logic [CW-1:0]     ph_r;
   logic [RANKS-1:0]  cs_n_r;
   logic [2:0]        strobe_r;
   logic [BA_W-1:0]   ba_r;
   logic [ADDR_W-1:0] addr_r;
   logic              cke_r;
   logic              odt_r;

   // ==========================================================
   // link clock: each level stands HALF mclk cycles; pins change on the
   // falling half so the device sees a stable setup at the rising crossing
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ck_r <= 1'b0;
         ph_r <= '0;
      end else if (ph_r == CW'(HALF - 1)) begin
         ck_r <= ~ck_r;
         ph_r <= '0;
      end else begin
         ph_r <= ph_r + 1'b1;
      end
   end

   // one take per link period, on the edge at which the clock falls
   assign req_ready = ck_r && (ph_r == CW'(HALF - 1));

   // ==========================================================
   // pin update, one command per link clock period
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cs_n_r   <= '1;
         strobe_r <= 3'h7;
         ba_r     <= '0;
         addr_r   <= '0;
         cke_r    <= 1'b0;
         odt_r    <= 1'b0;
      end else if (req_ready) begin
         cke_r <= req_cke;
         odt_r <= req_odt;
         if (req_valid && req_cmd != sdc_pkg::CMD_DES) begin
            cs_n_r <= ~(RANKS'(1) << req_rank);
            strobe_r <= req_cmd[2:0];
            ba_r   <= req_bank;
            addr_r <= req_addr;
         end else begin
            cs_n_r   <= '1;
            strobe_r <= 3'h7;
         end
      end
   end

   assign link.true_clock_input          = ck_r;
   assign link.complement_clock_input    = ~ck_r;
   assign link.cke                       = cke_r;
   assign link.cs_n                      = cs_n_r;
   assign link.ras_n                     = strobe_r[2];
   assign link.cas_n                     = strobe_r[1];
   assign link.we_n                      = strobe_r[0];
   assign link.ba                        = ba_r;
   assign link.addr                      = addr_r;
   assign link.termination_control_input = odt_r;
endmodule

// ---- rtl/sdc_link_if.sv ----
// command and address link between controller and device input stage
`timescale 1ns/10ps
interface sdc_link_if #(
   parameter int ADDR_W = sdc_pkg::ADDR_W,
   parameter int BA_W   = sdc_pkg::BA_W,
   parameter int RANKS  = 1
);
   logic              true_clock_input;           // link clock, true phase
   logic              complement_clock_input;     // link clock, complement phase
   logic              cke;                        // clock-gate input
   logic [RANKS-1:0]  cs_n;                       // active-low select, one per rank
   logic              ras_n;                      // row strobe
   logic              cas_n;                      // column strobe
   logic              we_n;                       // write enable
   logic [BA_W-1:0]   ba;                         // bank select
   logic [ADDR_W-1:0] addr;                       // address inputs
   logic              termination_control_input;  // on-die termination control

   modport host (
      output true_clock_input, complement_clock_input, cke, cs_n, ras_n, cas_n, we_n,
      output ba, addr, termination_control_input
   );
   modport dev (
      input true_clock_input, complement_clock_input, cke, cs_n, ras_n, cas_n, we_n,
      input ba, addr, termination_control_input
   );
endinterface

// ---- rtl/sdc_pkg.sv ----
// shared constants and types for the command input stage and its controller
package sdc_pkg;

   // ==========================================================
   // widths and field positions
   localparam int ADDR_W        = 15;  // address bus, narrow parts
   localparam int BA_W          = 3;   // bank-select inputs
   localparam int NUM_MODE_REGS = 4;   // base, extended, extended two, extended three
   localparam int MSEL_W        = 2;   // bank bits that pick the mode register
   localparam int AP_BIT        = 10;  // auto_precharge_addr_bit position
   localparam int TERM_LO_BIT   = 2;   // termination select, low bit in extended register
   localparam int TERM_HI_BIT   = 6;   // termination select, high bit in extended register

   // ==========================================================
   // mode register selection by bank bits
   localparam logic [1:0] MSEL_BASE  = 2'h0;
   localparam logic [1:0] MSEL_EXT   = 2'h1;
   localparam logic [1:0] MSEL_EXT2  = 2'h2;
   localparam logic [1:0] MSEL_EXT3  = 2'h3;

   // ==========================================================
   // reset values
   localparam logic [ADDR_W-1:0] MODE_RST = 15'h0000;

   // ==========================================================
   // timing: mclk 40 MHz, link clock is mclk divided by four; the three-stage pin
   // filter only passes a level that stands two mclk cycles, so one cycle is too short
   localparam int MCLK_PERIOD_PS = 25000;
   localparam int CK_HALF_CYC    = 2;   // mclk cycles per half period of the link clock

   // ==========================================================
   // command code {select_n, row strobe_n, column strobe_n, write_enable_n}
   typedef enum logic [3:0] {
      CMD_LMR = 4'h0,
      CMD_REF = 4'h1,
      CMD_PRE = 4'h2,
      CMD_ACT = 4'h3,
      CMD_WR  = 4'h4,
      CMD_RD  = 4'h5,
      CMD_RSV = 4'h6,
      CMD_NOP = 4'h7,
      CMD_DES = 4'h8
   } sdc_cmd_t;

   // power state of the device
   typedef enum logic [1:0] {
      PWR_ON,
      PWR_PPD,
      PWR_APD,
      PWR_SR
   } sdc_pwr_t;

endpackage

// ---- rtl/sdc_sync3.sv ----
// three-stage pin synchroniser, output follows once stages two and three agree
`timescale 1ns/10ps
module sdc_sync3 #(
   parameter int W = 1
) (
   input  wire logic         mclk,   // system clock
   input  wire logic         rst_n,  // synchronous reset, active low
   input  wire logic [W-1:0] d,      // asynchronous pin levels
   output logic      [W-1:0] q       // filtered, synchronised levels
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;

   // ==========================================================
   // stage one feeds only stage two, so metastability never spreads
   always_ff @(posedge mclk) begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
   end

   // a bit moves only when two late stages agree, filtering a one-cycle glitch
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         for (int i = 0; i < W; i++) begin
            if (s2_r[i] == s3_r[i]) begin
               q[i] <= s3_r[i];
            end
         end
      end
   end
endmodule

// ---- sim/sdc_link_chk.sv ----
// link checker: timing of the command and address pins between the two ends
`timescale 1ns/10ps
module sdc_link_chk #(
   parameter int ADDR_W = sdc_pkg::ADDR_W,
   parameter int BA_W   = sdc_pkg::BA_W,
   parameter int RANKS  = 1
) (
   input wire logic              mclk,                      // system clock
   input wire logic              rst_n,                     // sync reset
   input wire logic              true_clock_input,          // link clock
   input wire logic              complement_clock_input,    // link clock, inverted
   input wire logic              cke,                       // clock gate
   input wire logic [RANKS-1:0]  cs_n,                      // rank select
   input wire logic              ras_n,                     // row strobe
   input wire logic              cas_n,                     // column strobe
   input wire logic              we_n,                      // write enable
   input wire logic [BA_W-1:0]   ba,                        // bank select
   input wire logic [ADDR_W-1:0] addr,                      // address
   input wire logic              termination_control_input  // termination
);
   // ========
   // one clock domain, so clock and reset are given once
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   // ========
   // a command stands through the rising crossing, then the clock falls again
   sequence low_held_s;
      !true_clock_input && $stable({cke, cs_n, ras_n, cas_n, we_n, ba, addr,
                                    termination_control_input});
   endsequence
   sequence pins_held_s;
      true_clock_input && $stable({cke, cs_n, ras_n, cas_n, we_n, ba, addr,
                                   termination_control_input});
   endsequence
   sequence falls_again_s;
      !true_clock_input;
   endsequence

   // ========
   // clock phases opposite
   clk_pair_a: assert property (complement_clock_input == !true_clock_input)
      else $error("link clock phases not opposite");
   clk_toggle_a: assert property ($fell(true_clock_input) |=>
      !true_clock_input ##1 true_clock_input)
      else $error("link clock missed a toggle");
   pin_hold_a: assert property ($fell(true_clock_input) |=> low_held_s ##1
      pins_held_s [*2] ##1 falls_again_s)
      else $error("pins moved across the rising crossing");
   addr_edge_a: assert property ($changed(addr) |-> $fell(true_clock_input))
      else $error("address changed away from the falling clock");
   bank_edge_a: assert property ($changed(ba) |-> $fell(true_clock_input))
      else $error("bank select changed away from the falling clock");
   cmd_edge_a: assert property ($changed({ras_n, cas_n, we_n}) |-> $fell(true_clock_input))
      else $error("strobes changed away from the falling clock");
   sel_edge_a: assert property ($changed(cs_n) |-> $fell(true_clock_input))
      else $error("select changed away from the falling clock");
   gate_edge_a: assert property ($changed(cke) |-> $fell(true_clock_input))
      else $error("clock gate changed away from the falling clock");
endmodule

// ---- sim/tb_sdram_command_input_control.sv ----
// self-checking bench: controller end and device end joined over the link
`timescale 1ns/10ps
module tb_sdram_command_input_control;
   // ========
   // take edge to settled device outputs is seven edges; a gate or termination
   // change may wait four more for its take, and a mode load needs one more crossing
   localparam int LAT = 14;
   localparam int TMO = 3000;  // tests need well under a thousand cycles
   logic              mclk;
   logic              rst_n;
   logic              req_valid;
   logic              req_ready;
   sdc_pkg::sdc_cmd_t req_cmd;
   logic [0:0]        req_rank;
   logic [2:0]        req_bank;
   logic [14:0]       req_addr;
   logic              req_cke;
   logic              req_odt;
   logic              cmd_valid;
   sdc_pkg::sdc_cmd_t cmd_code;
   logic [2:0]        cmd_bank;
   logic [14:0]       cmd_addr;
   logic              cmd_ap;
   logic              mode_wr;
   logic [14:0]       mode_reg [4];
   logic [7:0]        bank_open;
   sdc_pkg::sdc_pwr_t pwr_state;
   logic              clk_active;
   logic              cmd_buf_en;
   logic              ck_buf_en;
   logic              term_on;
   int                num_errors;
   int                check_count;
   int                cycles;
   int                pulses;
   int                writes;

   // ========
   // both ends on one link, checker beside it
   sdc_link_if sdc_link_if_i ();
   sdc_host sdc_host_i (.mclk(mclk), .rst_n(rst_n), .req_valid(req_valid),
      .req_ready(req_ready), .req_cmd(req_cmd), .req_rank(req_rank), .req_bank(req_bank),
      .req_addr(req_addr), .req_cke(req_cke), .req_odt(req_odt), .link(sdc_link_if_i.host));
   sdc_device sdc_device_i (.mclk(mclk), .rst_n(rst_n), .link(sdc_link_if_i.dev),
      .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_bank(cmd_bank), .cmd_addr(cmd_addr),
      .cmd_ap(cmd_ap), .mode_wr(mode_wr), .mode_reg(mode_reg), .bank_open(bank_open),
      .pwr_state(pwr_state), .clk_active(clk_active), .cmd_buf_en(cmd_buf_en),
      .ck_buf_en(ck_buf_en), .term_on(term_on));
   sdc_link_chk #(.ADDR_W(sdc_pkg::ADDR_W), .BA_W(sdc_pkg::BA_W), .RANKS(1)) sdc_link_chk_i (
      .mclk(mclk), .rst_n(rst_n),
      .true_clock_input(sdc_link_if_i.true_clock_input),
      .complement_clock_input(sdc_link_if_i.complement_clock_input),
      .cke(sdc_link_if_i.cke), .cs_n(sdc_link_if_i.cs_n), .ras_n(sdc_link_if_i.ras_n),
      .cas_n(sdc_link_if_i.cas_n), .we_n(sdc_link_if_i.we_n), .ba(sdc_link_if_i.ba),
      .addr(sdc_link_if_i.addr),
      .termination_control_input(sdc_link_if_i.termination_control_input));

   // ========
   // clock, cycle ceiling and decoded-command count
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      // a hang must still reach the closing report
      if (cycles == TMO) begin
         num_errors = num_errors + 1;
         end_of_test();
      end
      if (cmd_valid === 1'b1) begin
         pulses <= pulses + 1;
      end
      if (mode_wr === 1'b1) begin
         writes <= writes + 1;
      end
   end

   // ========
   // shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // valid stays up after the take so a second call can follow back to back
   task automatic send(input sdc_pkg::sdc_cmd_t cmd, input logic [2:0] bank,
                       input logic [14:0] addr, input logic [0:0] rank);
      int n;
      n = 0;
      req_valid <= 1'b1;
      req_cmd   <= cmd;
      req_bank  <= bank;
      req_addr  <= addr;
      req_rank  <= rank;
      @(negedge mclk);
      while (req_ready !== 1'b1 && n < 8) begin
         @(negedge mclk);
         n++;
      end
      chk(req_ready, 1'b1);
      @(posedge mclk);
   endtask
   task automatic settle();
      req_valid <= 1'b0;
      repeat (LAT) @(posedge mclk);
   endtask
   task automatic run(input sdc_pkg::sdc_cmd_t cmd, input logic [2:0] bank,
                      input logic [14:0] addr);
      send(cmd, bank, addr, 1'h0);
      settle();
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // ========
   // scenarios
   task automatic t_mode();
      int p;
      int w;
      p = pulses;
      w = writes;
      // op code lands in the chosen register, top bank bit ignored
      for (int i = 0; i < 4; i++) begin
         send(sdc_pkg::CMD_LMR, {i[0], i[1:0]}, 15'h1230 | 15'(i), 1'h0);
      end
      settle();
      for (int i = 0; i < 4; i++) begin
         chk(mode_reg[i], 15'h1230 | 15'(i));
      end
      chk(pulses - p, 32'h0000_0004);
      chk(writes - w, 32'h0000_0004);
      $display("test mode load done");
   endtask
   task automatic t_rows();
      run(sdc_pkg::CMD_ACT, 3'h2, 15'h5a5c);
      chk(cmd_code, sdc_pkg::CMD_ACT);
      chk(cmd_bank, 3'h2);
      chk(cmd_addr, 15'h5a5c);
      chk(bank_open, 8'h04);
      run(sdc_pkg::CMD_RD, 3'h2, 15'h0040);
      chk(cmd_ap, 1'h0);
      chk(bank_open, 8'h04);
      run(sdc_pkg::CMD_WR, 3'h2, 15'h0440);
      chk(cmd_code, sdc_pkg::CMD_WR);
      chk(cmd_ap, 1'h1);
      chk(bank_open, 8'h00);
      send(sdc_pkg::CMD_ACT, 3'h1, 15'h0001, 1'h0);
      send(sdc_pkg::CMD_ACT, 3'h5, 15'h0002, 1'h0);
      settle();
      chk(bank_open, 8'h22);
      run(sdc_pkg::CMD_PRE, 3'h1, 15'h0000);
      chk(bank_open, 8'h20);
      run(sdc_pkg::CMD_PRE, 3'h3, 15'h0400);
      chk(bank_open, 8'h00);
      $display("test rows done");
   endtask
   task automatic t_desel();
      int p;
      p = pulses;
      // unselected rank and deselect are masked
      send(sdc_pkg::CMD_ACT, 3'h6, 15'h0123, 1'h1);
      send(sdc_pkg::CMD_DES, 3'h6, 15'h0123, 1'h0);
      settle();
      chk(bank_open, 8'h00);
      chk(pulses - p, 32'h0000_0000);
      chk(cmd_code, sdc_pkg::CMD_PRE);
      $display("test deselect done");
   endtask
   task automatic t_noaddr();
      // refresh and no-op leave bank and address alone
      send(sdc_pkg::CMD_REF, 3'h7, 15'h7fff, 1'h0);
      settle();
      chk(cmd_code, sdc_pkg::CMD_REF);
      chk(cmd_bank, 3'h3);
      chk(cmd_addr, 15'h0400);
      chk(cmd_ap, 1'h0);
      run(sdc_pkg::CMD_NOP, 3'h5, 15'h7bff);
      chk(cmd_code, sdc_pkg::CMD_NOP);
      chk(cmd_addr, 15'h0400);
      $display("test unused address done");
   endtask
   task automatic t_term();
      // termination input obeyed only once enabled by mode load
      req_odt <= 1'b1;
      settle();
      chk(term_on, 1'h0);
      run(sdc_pkg::CMD_LMR, 3'h1, 15'h0004);
      chk(term_on, 1'h1);
      req_odt <= 1'b0;
      settle();
      chk(term_on, 1'h0);
      req_odt <= 1'b1;
      settle();
      $display("test termination done");
   endtask
   task automatic t_power();
      // power-down kinds, buffer gating and exits
      run(sdc_pkg::CMD_ACT, 3'h0, 15'h0011);
      req_cke <= 1'b0;
      settle();
      chk(pwr_state, sdc_pkg::PWR_APD);
      chk(clk_active, 1'h0);
      chk(cmd_buf_en, 1'h0);
      chk(ck_buf_en, 1'h1);
      chk(term_on, 1'h1);
      run(sdc_pkg::CMD_ACT, 3'h4, 15'h0022);
      chk(bank_open, 8'h01);
      req_cke <= 1'b1;
      settle();
      chk(pwr_state, sdc_pkg::PWR_ON);
      chk(clk_active, 1'h1);
      run(sdc_pkg::CMD_PRE, 3'h0, 15'h0400);
      req_cke <= 1'b0;
      settle();
      chk(pwr_state, sdc_pkg::PWR_PPD);
      req_cke <= 1'b1;
      settle();
      chk(pwr_state, sdc_pkg::PWR_ON);
      req_cke <= 1'b0;
      run(sdc_pkg::CMD_REF, 3'h0, 15'h0000);
      chk(pwr_state, sdc_pkg::PWR_SR);
      chk(ck_buf_en, 1'h0);
      chk(term_on, 1'h0);
      req_cke <= 1'b1;
      settle();
      chk(pwr_state, sdc_pkg::PWR_ON);
      chk(clk_active, 1'h1);
      $display("test power done");
   endtask

   // ========
   // main sequence; the gate starts low, so the first crossing enters power-down
   initial begin
      rst_n = 1'b0;
      req_valid = 1'b0;
      req_cmd = sdc_pkg::CMD_NOP;
      req_rank = 1'h0;
      req_bank = 3'h0;
      req_addr = 15'h0000;
      req_cke = 1'b1;
      req_odt = 1'b0;
      num_errors = 0;
      check_count = 0;
      cycles = 0;
      pulses = 0;
      writes = 0;
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      settle();
      settle();
      chk(pwr_state, sdc_pkg::PWR_ON);
      chk(bank_open, 8'h00);
      t_mode();
      t_rows();
      t_desel();
      t_noaddr();
      t_term();
      t_power();
      end_of_test();
   end
endmodule
